// >>> rtl/mcc_pkg.sv
/*
 * mcc_pkg: shared constants for the multichannel comm converter:
 * control word field layout, fixed core addresses, order encoding.
 * Assumes 37-bit memory words, bit n of a word held at index n-1.
 */
package mcc_pkg;

	// ****************************************
	// word and field layout
	// ****************************************
	localparam int          WORD_W        = 37;
	localparam int          ADDR_W        = 17;
	localparam int          CHAR_W        = 6;
	localparam int          CNT_W         = 3;
	localparam int          WCNT_W        = 9;
	localparam int          ADDR_LSB      = 0;
	localparam int          CNT_LSB       = 18;
	localparam int          WCNT_LSB      = 21;
	localparam int          BIT_ISIGN     = 30;
	localparam int          BIT_CTRL      = 31;
	localparam int          BIT_PERR      = 32;
	localparam int          BIT_INUSE     = 36;
	localparam int          SLOT0_LSB     = 30;
	localparam logic [2:0]  CHARS_PER_WORD = 3'h6;

	// ****************************************
	// fixed core locations (decimal 100..177)
	// ****************************************
	localparam logic [16:0] RX_CW_BASE    = 17'h00064;
	localparam logic [16:0] TX_CW_BASE    = 17'h00084;
	localparam logic [16:0] CTRL_CHAR_LOC = 17'h000B1;

	// ****************************************
	// processor orders on the memory output bus
	// ****************************************
	localparam int          OP_LSB        = 30;
	localparam logic [5:0]  OP_LOAD_TX    = 6'h01;

	// ****************************************
	// sequencing states
	// ****************************************
	typedef enum logic [8:0] {
		ST_IDLE     = 9'h001,
		ST_CW_RD    = 9'h002,
		ST_CW_WAIT  = 9'h004,
		ST_CW_WR    = 9'h008,
		ST_DAT_RD   = 9'h010,
		ST_DAT_WAIT = 9'h020,
		ST_DAT_WR   = 9'h040,
		ST_CC_WR    = 9'h080,
		ST_SEND     = 9'h100
	} mcc_state_t;

	// parity bit that makes a character plus parity odd
	function automatic logic mcc_odd_par(input logic [5:0] c);
		mcc_odd_par = ~(^c);
	endfunction : mcc_odd_par

endpackage : mcc_pkg

// >>> rtl/mcc_poll.sv
/*
 * mcc_poll: active-channel bit register, all-zero detector and
 * round-robin poll counter. Set is a one-cycle vector; clear is a one-cycle enable with an index.
 * Assumes the caller holds the counter while a channel is serviced.
 */
`timescale 1ns/1ns
module mcc_poll
	import mcc_pkg::*;
#(
	parameter int N = 32
)(
	// clock and reset
	input  wire logic                 core_clk,
	input  wire logic                 rst,
	// bit control
	input  wire logic [N-1:0]         set_bits,
	input  wire logic                 clr_en,
	input  wire logic [$clog2(N)-1:0] clr_idx,
	input  wire logic                 hold,
	// poll status
	output logic [N-1:0]              active_bits,
	output logic [$clog2(N)-1:0]      poll_count,
	output logic                      any_active,
	output logic                      found
);

	// ****************************************
	// bit register and scanning counter
	// ****************************************
	logic [N-1:0]         bits_reg;
	logic [N-1:0]         bits_next;
	logic [N-1:0]         clr_mask;
	logic [$clog2(N)-1:0] ctr_reg;
	logic [$clog2(N)-1:0] ctr_next;

	// set wins over clear in the same cycle
	assign clr_mask   = clr_en ? (N'(1) << clr_idx) : '0;
	assign bits_next  = (bits_reg & ~clr_mask) | set_bits;
	assign any_active = |bits_reg;
	assign found      = bits_reg[ctr_reg];
	// step past a served channel, so a re-armed one cannot starve the rest
	assign ctr_next   = (clr_en || (any_active && !found && !hold)) ?
		ctr_reg + 1'b1 : ctr_reg;

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			bits_reg <= '0;
			ctr_reg  <= '0;
		end
		else
		begin
			bits_reg <= bits_next;
			ctr_reg  <= ctr_next;
		end
	end

	assign active_bits = bits_reg;
	assign poll_count  = ctr_reg;

endmodule : mcc_poll

// >>> rtl/mcc_char.sv
/*
 * mcc_char: six-bit character slot pick and merge on a data word.
 * Slot 0 sits in bits 31-36, slot 5 in bits 1-6. Purely combinational.
 */
`timescale 1ns/1ns
module mcc_char
	import mcc_pkg::*;
(
	// slot selection
	input  wire logic [WORD_W-1:0] word_in,
	input  wire logic [2:0]        slot,
	input  wire logic [CHAR_W-1:0] char_in,
	// results
	output logic [CHAR_W-1:0]      char_out,
	output logic [WORD_W-1:0]      word_out
);

	// ****************************************
	// slot decode
	// ****************************************
	logic [5:0]        lsb;
	logic [WORD_W-1:0] mask;

	assign lsb      = 6'(SLOT0_LSB) - 6'(slot) * 6'h06;
	assign mask     = WORD_W'(6'h3F) << lsb;
	assign char_out = word_in[lsb +: CHAR_W];
	assign word_out = (word_in & ~mask) | (WORD_W'(char_in) << lsb);

endmodule : mcc_char

// >>> rtl/mcc_top.sv
/*
 * mcc_top: multichannel comm converter sequencer. Services receive
 * strobes and transmit orders through control words in core memory.
 * Assumes memory takes a request on the grant cycle and returns read
 * data later with mem_data_valid; one access outstanding at a time.
 */
// How it works
// - takes processor orders; serves 32 two-way channels
// - control words at fixed core addresses 100-177
// - receive word: address, char count, word count
// - receive flags: sign, control, parity error, in-use
// - transmit word: address, chars left, words left
// - control mode sends bits 31-36 only
// - receiver strobe sets its strobe-active bit
// - load order sets transmitter-active bit
// - nonzero strobe bits start the receive poll
// - found channel requests memory, counter addresses word
// - fetched word held; strobe bit cleared
// - receive word updated with flags, written back
// - data char merged into data word, rewritten
// - nonzero transmit bits start transmit poll, fetch
// - transmit bit cleared; word updated, written back
// - character picked, parity added, sent to channel
// - interrupts: transmit done, message done, control char
// - odd parity checked; error drives parity lamp
`timescale 1ns/1ns
module mcc_top
	import mcc_pkg::*;
#(
	parameter int NCH = 32
)(
	// clock and reset
	input  wire logic                    core_clk,
	input  wire logic                    rst,
	// processor orders
	input  wire logic                    io_order_valid,
	// core memory
	output logic                         mem_busy_req,
	input  wire logic                    mem_grant,
	output logic [ADDR_W-1:0]            memory_address_bus,
	output logic                         mem_write,
	output logic [WORD_W-1:0]            mem_wdata,
	input  wire logic [WORD_W-1:0]       memory_output_bus,
	input  wire logic                    mem_data_valid,
	// receivers
	input  wire logic [NCH-1:0]          rx_strobe,
	input  wire logic [NCH*CHAR_W-1:0]   rx_data,
	input  wire logic [NCH-1:0]          rx_parity,
	input  wire logic [NCH-1:0]          rx_ctrl,
	// transmitters
	output logic                         tx_valid,
	output logic [$clog2(NCH)-1:0]       tx_chan,
	output logic [CHAR_W-1:0]            tx_char,
	output logic                         tx_parity,
	output logic                         tx_ctrl,
	// interrupts and lamps
	output logic                         irq_transmit_done,
	output logic                         irq_message_done,
	output logic                         irq_control_char,
	output logic [$clog2(NCH)-1:0]       irq_chan,
	input  wire logic                    lamp_clear,
	output logic                         converter_parity_error_lamp,
	// status
	output logic [NCH-1:0]               strobe_active_bits,
	output logic [NCH-1:0]               transmitter_active_bits,
	output logic                         busy
);

	localparam int CW = $clog2(NCH);

	// ****************************************
	// state and holding registers
	// ****************************************
	mcc_state_t        state_reg;
	mcc_state_t        state_next;
	logic              rx_mode_reg;
	logic [CW-1:0]     chan_reg;
	logic [WORD_W-1:0] control_word_holding_reg;
	logic [CHAR_W-1:0] rch_reg;
	logic              rpar_reg;
	logic              rctl_reg;
	logic              done_reg;
	logic [ADDR_W-1:0] addr_reg;
	logic              we_reg;
	logic [WORD_W-1:0] wdata_reg;
	logic              lamp_reg;
	logic              txv_reg;
	logic [CHAR_W-1:0] txc_reg;
	logic              txp_reg;
	logic              txk_reg;
	logic              irq_t_reg;
	logic              irq_m_reg;
	logic              irq_c_reg;
	logic [CW-1:0]     irq_ch_reg;

	// ****************************************
	// poll units
	// ****************************************
	logic [CW-1:0]     receive_poll_counter;
	logic [CW-1:0]     transmit_poll_counter;
	logic              receive_zero_detector;
	logic              transmit_zero_detector;
	logic              rx_found;
	logic              tx_found;
	logic              load_transmit_order;
	logic              rearm;
	logic              cw_taken;
	logic [NCH-1:0]    tx_set;
	logic              hold;

	assign hold                = (state_reg != ST_IDLE);
	assign cw_taken            = (state_reg == ST_CW_WAIT) && mem_data_valid;
	assign load_transmit_order = io_order_valid &&
		(memory_output_bus[OP_LSB +: 6] == OP_LOAD_TX);
	assign rearm               = (state_reg == ST_SEND) && !done_reg;
	assign tx_set              = (load_transmit_order ? (NCH'(1) << memory_output_bus[CW-1:0])
		: '0) | (rearm ? (NCH'(1) << chan_reg) : '0);

	mcc_poll #(.N(NCH)) u_rx_poll (
		.core_clk    (core_clk),
		.rst         (rst),
		.set_bits    (rx_strobe),
		.clr_en      (cw_taken && rx_mode_reg),
		.clr_idx     (chan_reg),
		.hold        (hold),
		.active_bits (strobe_active_bits),
		.poll_count  (receive_poll_counter),
		.any_active  (receive_zero_detector),
		.found       (rx_found)
	);

	mcc_poll #(.N(NCH)) u_tx_poll (
		.core_clk    (core_clk),
		.rst         (rst),
		.set_bits    (tx_set),
		.clr_en      (cw_taken && !rx_mode_reg),
		.clr_idx     (chan_reg),
		.hold        (hold),
		.active_bits (transmitter_active_bits),
		.poll_count  (transmit_poll_counter),
		.any_active  (transmit_zero_detector),
		.found       (tx_found)
	);

	// ****************************************
	// control word decode and update
	// ****************************************
	logic [WORD_W-1:0] cwi;
	logic [ADDR_W-1:0] f_addr;
	logic [CNT_W-1:0]  f_cnt;
	logic [WCNT_W-1:0] f_wcnt;
	logic              f_inuse;
	logic              f_ctlmode;
	logic              rx_perr;
	logic [CNT_W-1:0]  rx_cnt1;
	logic              rx_wrap;
	logic [CNT_W-1:0]  tx_rem;
	logic [CNT_W-1:0]  tx_rem1;
	logic              tx_wrap;
	logic              adv;
	logic [ADDR_W-1:0] n_addr;
	logic [WCNT_W-1:0] n_wcnt;
	logic [CNT_W-1:0]  n_cnt;
	logic [WORD_W-1:0] cw_new;
	logic              skip;

	assign cwi       = memory_output_bus;
	assign f_addr    = cwi[ADDR_LSB +: ADDR_W];
	assign f_cnt     = cwi[CNT_LSB +: CNT_W];
	assign f_wcnt    = cwi[WCNT_LSB +: WCNT_W];
	assign f_inuse   = cwi[BIT_INUSE];
	assign f_ctlmode = cwi[BIT_CTRL];
	assign rx_perr   = ~(^{rch_reg, rpar_reg});
	assign rx_cnt1   = f_cnt + 1'b1;
	assign rx_wrap   = (rx_cnt1 == CHARS_PER_WORD);
	// a zero remaining count means a fresh word of six
	assign tx_rem    = (f_cnt == '0) ? CHARS_PER_WORD : f_cnt;
	assign tx_rem1   = tx_rem - 1'b1;
	assign tx_wrap   = f_ctlmode || (tx_rem1 == '0);
	assign adv       = rx_mode_reg ? (!rctl_reg && rx_wrap) : tx_wrap;
	assign n_addr    = adv ? f_addr + 1'b1 : f_addr;
	assign n_wcnt    = adv ? f_wcnt - 1'b1 : f_wcnt;
	assign n_cnt     = rx_mode_reg ? (rctl_reg ? f_cnt : (rx_wrap ? '0 : rx_cnt1))
		: (f_ctlmode ? f_cnt : tx_rem1);
	// idle channels, and transmits with nothing left, are dropped
	assign skip      = !f_inuse || (!rx_mode_reg && (f_wcnt == '0));

	always_comb
	begin
		cw_new = cwi;
		cw_new[ADDR_LSB +: ADDR_W] = n_addr;
		cw_new[CNT_LSB +: CNT_W]   = n_cnt;
		cw_new[WCNT_LSB +: WCNT_W] = n_wcnt;
		if (rx_mode_reg)
		begin
			if (rctl_reg)
				cw_new[BIT_CTRL] = 1'b1;
			if (rx_perr)
				cw_new[BIT_PERR] = 1'b1;
		end
	end

	// ****************************************
	// character slot handling
	// ****************************************
	logic [2:0]        slot;
	logic [CHAR_W-1:0] pick;
	logic [WORD_W-1:0] merged;
	logic [ADDR_W-1:0] h_addr;
	logic [CNT_W-1:0]  h_cnt;
	logic              h_ctl;

	assign h_addr = control_word_holding_reg[ADDR_LSB +: ADDR_W];
	assign h_cnt  = control_word_holding_reg[CNT_LSB +: CNT_W];
	assign h_ctl  = control_word_holding_reg[BIT_CTRL];
	assign slot   = rx_mode_reg ? h_cnt : (h_ctl ? 3'h0 :
		(CHARS_PER_WORD - ((h_cnt == '0) ? CHARS_PER_WORD : h_cnt)));

	mcc_char u_char (
		.word_in  (memory_output_bus),
		.slot     (slot),
		.char_in  (rch_reg),
		.char_out (pick),
		.word_out (merged)
	);

	// ****************************************
	// sequencing
	// ****************************************
	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			ST_IDLE:     if (rx_found || tx_found) state_next = ST_CW_RD;
			ST_CW_RD:    if (mem_grant) state_next = ST_CW_WAIT;
			ST_CW_WAIT:  if (mem_data_valid) state_next = skip ? ST_IDLE : ST_CW_WR;
			ST_CW_WR:    if (mem_grant) state_next = (rx_mode_reg && rctl_reg) ? ST_CC_WR
				: ST_DAT_RD;
			ST_DAT_RD:   if (mem_grant) state_next = ST_DAT_WAIT;
			ST_DAT_WAIT: if (mem_data_valid) state_next = rx_mode_reg ? ST_DAT_WR : ST_SEND;
			ST_DAT_WR:   if (mem_grant) state_next = ST_IDLE;
			ST_CC_WR:    if (mem_grant) state_next = ST_IDLE;
			ST_SEND:     state_next = ST_IDLE;
		endcase
	end

	logic pick_rx;

	assign pick_rx = rx_found;  // receive served first when both wait

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			state_reg <= ST_IDLE;
			rx_mode_reg <= 1'b0;
			chan_reg <= '0;
			control_word_holding_reg <= '0;
			rch_reg <= '0;
			rpar_reg <= 1'b0;
			rctl_reg <= 1'b0;
			done_reg <= 1'b0;
			addr_reg <= '0;
			we_reg <= 1'b0;
			wdata_reg <= '0;
		end
		else
		begin
			state_reg <= state_next;
			if (state_reg == ST_IDLE && (rx_found || tx_found))
			begin
				rx_mode_reg <= pick_rx;
				chan_reg <= pick_rx ? receive_poll_counter : transmit_poll_counter;
				rch_reg <= rx_data[receive_poll_counter*CHAR_W +: CHAR_W];
				rpar_reg <= rx_parity[receive_poll_counter];
				rctl_reg <= rx_ctrl[receive_poll_counter];
				addr_reg <= pick_rx ? RX_CW_BASE + ADDR_W'(receive_poll_counter)
					: TX_CW_BASE + ADDR_W'(transmit_poll_counter);
				we_reg <= 1'b0;
			end
			if (cw_taken)
			begin
				control_word_holding_reg <= cwi;
				done_reg <= (n_wcnt == '0);
				wdata_reg <= cw_new;
				we_reg <= 1'b1;
			end
			if (state_reg == ST_CW_WR && mem_grant)
			begin
				addr_reg <= (rx_mode_reg && rctl_reg) ? CTRL_CHAR_LOC : h_addr;
				wdata_reg <= WORD_W'({chan_reg, rch_reg});
				we_reg <= rx_mode_reg && rctl_reg;
			end
			if (state_reg == ST_DAT_WAIT && mem_data_valid)
			begin
				wdata_reg <= merged;
				we_reg <= 1'b1;
			end
		end
	end

	// ****************************************
	// transmitter, interrupts, lamp
	// ****************************************
	logic dat_ok;
	logic cc_ok;

	assign dat_ok = (state_reg == ST_DAT_WR) && mem_grant;
	assign cc_ok  = (state_reg == ST_CC_WR) && mem_grant;

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			txv_reg <= 1'b0;
			txc_reg <= '0;
			txp_reg <= 1'b0;
			txk_reg <= 1'b0;
			irq_t_reg <= 1'b0;
			irq_m_reg <= 1'b0;
			irq_c_reg <= 1'b0;
			irq_ch_reg <= '0;
			lamp_reg <= 1'b0;
		end
		else
		begin
			txv_reg <= (state_reg == ST_DAT_WAIT) && mem_data_valid && !rx_mode_reg;
			if ((state_reg == ST_DAT_WAIT) && mem_data_valid && !rx_mode_reg)
			begin
				txc_reg <= pick;
				txp_reg <= mcc_odd_par(pick);
				txk_reg <= h_ctl;
			end
			irq_t_reg <= (state_reg == ST_SEND) && done_reg;
			irq_m_reg <= dat_ok && done_reg;
			irq_c_reg <= cc_ok;
			if (((state_reg == ST_DAT_WAIT) && mem_data_valid) || dat_ok || cc_ok)
				irq_ch_reg <= chan_reg;
			// a new error wins over a clear in the same cycle
			lamp_reg <= (lamp_reg && !lamp_clear) || (cw_taken && rx_mode_reg && rx_perr);
		end
	end

	assign mem_busy_req = (state_reg == ST_CW_RD) || (state_reg == ST_CW_WR) ||
		(state_reg == ST_DAT_RD) || (state_reg == ST_DAT_WR) || (state_reg == ST_CC_WR);
	assign memory_address_bus          = addr_reg;
	assign mem_write                   = we_reg;
	assign mem_wdata                   = wdata_reg;
	assign tx_valid                    = txv_reg;
	assign tx_chan                     = irq_ch_reg;
	assign tx_char                     = txc_reg;
	assign tx_parity                   = txp_reg;
	assign tx_ctrl                     = txk_reg;
	assign irq_transmit_done           = irq_t_reg;
	assign irq_message_done            = irq_m_reg;
	assign irq_control_char            = irq_c_reg;
	assign irq_chan                    = irq_ch_reg;
	assign converter_parity_error_lamp = lamp_reg;
	assign busy                        = hold;

endmodule : mcc_top

// >>> tb/mcc_core_mem.sv
/* mcc_core_mem: core memory and processor order source for mcc_top.
   assumes bench drives slow; order sent only while converter idle */
`timescale 1ns/1ns
module mcc_core_mem
	import mcc_pkg::*;
(
	// clock, reset, pacing
	input wire logic core_clk,
	input wire logic rst,
	input wire logic slow,
	// memory side
	input wire logic mem_busy_req,
	output logic mem_grant,
	input wire logic [ADDR_W-1:0] memory_address_bus,
	input wire logic mem_write,
	input wire logic [WORD_W-1:0] mem_wdata,
	output logic [WORD_W-1:0] memory_output_bus,
	output logic mem_data_valid,
	output logic io_order_valid
);
	logic [WORD_W-1:0] mem [0:1023];
	logic [WORD_W-1:0] ord_word;
	logic [WORD_W-1:0] d_s;
	logic [9:0] a_s;
	logic [9:0] rd_a;
	logic tk;
	logic wr;
	logic ord_req = 1'b0;
	int rd_cnt = 0;
	int gcnt = 0;

	// ****************
	// memory and bus
	// ****************
	initial
	begin
		foreach (mem[i]) mem[i] = '0;
		{mem_grant, mem_data_valid, io_order_valid} = 3'h0;
		memory_output_bus = '0;
		forever
		begin
			@(posedge core_clk);
			tk = mem_busy_req && mem_grant;
			wr = mem_write;
			a_s = memory_address_bus[9:0];
			d_s = mem_wdata;
			#1;
			mem_data_valid = (rd_cnt == 1) && !rst;
			if (rd_cnt > 0)
				rd_cnt = rd_cnt - 1;
			if (tk && wr && !rst)
				mem[a_s] = d_s;
			if (tk && !wr && !rst)
			begin
				rd_a = a_s;
				rd_cnt = slow ? 3 : 1;
			end
			gcnt = gcnt + 1;
			// slow mode grants only half the time
			mem_grant = !rst && (!slow || gcnt[1]);
			io_order_valid = ord_req && !rst;
			ord_req = 1'b0;
			// released bus toggles so stale data never looks valid
			if (io_order_valid)
				memory_output_bus = ord_word;
			else if (mem_data_valid)
				memory_output_bus = mem[rd_a];
			else
				memory_output_bus = ~memory_output_bus;
		end
	end

	task automatic send_order(input logic [5:0] op, input logic [4:0] ch);
		@(posedge core_clk);
		ord_word = '0;
		ord_word[OP_LSB+:6] = op;
		ord_word[4:0] = ch;
		ord_req = 1'b1;
		repeat (2) @(posedge core_clk);
		#1;
	endtask : send_order
endmodule : mcc_core_mem

// >>> tb/mcc_top_chk.sv
/* mcc_top_chk: port assertions for mcc_top.
   assumes one core_clk domain and async active-high rst */
`timescale 1ns/1ns
module mcc_top_chk
	import mcc_pkg::*;
#(
	parameter int NCH = 32
)(
	// clock, reset
	input wire logic core_clk,
	input wire logic rst,
	// orders, memory
	input wire logic io_order_valid,
	input wire logic [WORD_W-1:0] memory_output_bus,
	input wire logic mem_busy_req,
	input wire logic mem_grant,
	input wire logic [ADDR_W-1:0] memory_address_bus,
	// channels
	input wire logic [NCH-1:0] rx_strobe,
	input wire logic [NCH-1:0] strobe_active_bits,
	input wire logic [NCH-1:0] transmitter_active_bits,
	input wire logic busy,
	input wire logic tx_valid,
	input wire logic [CHAR_W-1:0] tx_char,
	input wire logic tx_parity,
	// events
	input wire logic irq_transmit_done,
	input wire logic irq_message_done,
	input wire logic irq_control_char,
	input wire logic lamp_clear,
	input wire logic converter_parity_error_lamp
);
	// ****************
	// properties
	// ****************
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	AST_RX_SET: assert property (
		|rx_strobe |=> (strobe_active_bits & $past(rx_strobe)) == $past(rx_strobe))
		else $error("strobe bit not set");
	AST_ORDER_SET: assert property (
		io_order_valid && memory_output_bus[OP_LSB+:6] == OP_LOAD_TX
		|=> transmitter_active_bits[$past(memory_output_bus[4:0])])
		else $error("transmit bit not set");
	AST_POLL_START: assert property (
		(strobe_active_bits != '0 || transmitter_active_bits != '0) && !busy
		|-> ##[0:40] busy)
		else $error("poll never started");
	AST_REQ_HOLD: assert property (
		mem_busy_req && !mem_grant
		|=> mem_busy_req && $stable(memory_address_bus))
		else $error("request dropped before grant");
	AST_TX_PARITY: assert property (
		tx_valid |-> tx_parity == ~^tx_char)
		else $error("transmit parity not odd");
	AST_TX_DONE: assert property (
		irq_transmit_done |-> $past(tx_valid))
		else $error("transmit done without char");
	AST_LAMP_HOLD: assert property (
		converter_parity_error_lamp && !lamp_clear |=> converter_parity_error_lamp)
		else $error("parity lamp lost");
	AST_IDLE_QUIET: assert property (
		!busy |-> !mem_busy_req && !tx_valid)
		else $error("memory request while idle");

	cover property (irq_message_done);
	cover property (irq_control_char);
	cover property (irq_transmit_done);
endmodule : mcc_top_chk

bind mcc_top mcc_top_chk #(.NCH(NCH)) u_chk (.*);

// >>> tb/tb_mcc_top.sv
/* tb_mcc_top: directed bench for mcc_top.
   assumes mcc_core_mem as memory and order source */
`timescale 1ns/1ns
module tb_mcc_top;
	import mcc_pkg::*;
	localparam int NCH = 32;
	logic core_clk, rst, slow, lamp_clear, io_order_valid, busy;
	logic mem_busy_req, mem_grant, mem_write, mem_data_valid;
	logic [ADDR_W-1:0] memory_address_bus;
	logic [WORD_W-1:0] mem_wdata, memory_output_bus;
	logic [NCH-1:0] rx_strobe, rx_parity, rx_ctrl;
	logic [NCH-1:0] strobe_active_bits, transmitter_active_bits;
	logic [NCH*CHAR_W-1:0] rx_data;
	logic tx_valid, tx_parity, tx_ctrl, converter_parity_error_lamp;
	logic irq_transmit_done, irq_message_done, irq_control_char;
	logic [4:0] tx_chan, irq_chan;
	logic [CHAR_W-1:0] tx_char;
	logic [12:0] txq [$];
	int error_cnt = 0;
	int checks = 0;
	int n_td = 0;
	int n_md = 0;
	int n_cc = 0;

	mcc_top #(.NCH(NCH)) dut (.*);
	mcc_core_mem mem_m (.*);

	initial
	begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	always @(posedge core_clk)
	begin
		if (tx_valid === 1'b1)
			txq.push_back({tx_ctrl, tx_parity, tx_chan, tx_char});
		n_td += (irq_transmit_done === 1'b1);
		n_md += (irq_message_done === 1'b1);
		n_cc += (irq_control_char === 1'b1);
	end

	// ****************
	// helpers
	// ****************
	function automatic logic [WORD_W-1:0] cw(logic pe, logic k, logic [8:0] w,
		logic [2:0] n, logic [16:0] a);
		cw = {1'b1, 3'h0, pe, k, 1'b0, w, n, 1'b0, a};
	endfunction : cw

	task automatic chk(input string nm, input logic [WORD_W-1:0] e, input logic [WORD_W-1:0] g);
		checks++;
		if (g !== e)
		begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic tally_and_finish();
		if (error_cnt == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : tally_and_finish

	task automatic wait_idle();
		int i;
		for (i = 0; i < 3000; i++)
		begin
			@(posedge core_clk);
			if (busy === 1'b0 && strobe_active_bits === '0 && transmitter_active_bits === '0)
				break;
		end
		if (i == 3000)
		begin
			error_cnt++;
			$display("[FAIL] idle expected 1 seen 0");
			tally_and_finish();
		end
		repeat (4) @(posedge core_clk);
		#1;
	endtask : wait_idle

	task automatic strobe(input int ch, input logic [5:0] c, input logic p, input logic k);
		rx_data[ch*6+:6] = c;
		rx_parity[ch] = p;
		rx_ctrl[ch] = k;
		rx_strobe[ch] = 1'b1;
		@(posedge core_clk);
		#1;
		rx_strobe = '0;
		@(posedge core_clk);
		#1;
	endtask : strobe

	// ****************
	// scenarios
	// ****************
	task automatic t_rx_data();
		mem_m.mem[10'h064] = cw(0, 0, 9'h002, 3'h0, 17'h00200);
		mem_m.mem[10'h200] = 37'h00_0000_0155;
		strobe(0, 6'h2A, ~^6'h2A, 1'b0);
		wait_idle();
		chk("rx cw", cw(0, 0, 9'h002, 3'h1, 17'h00200), mem_m.mem[10'h064]);
		chk("rx word", 37'h0A_8000_0155, mem_m.mem[10'h200]);
		strobe(6, 6'h01, 1'b0, 1'b0);
		wait_idle();
		chk("idle cw", '0, mem_m.mem[10'h06A]);
	endtask : t_rx_data

	task automatic t_rx_msg();
		slow = 1'b1;
		mem_m.mem[10'h065] = cw(0, 0, 9'h001, 3'h5, 17'h00210);
		strobe(1, 6'h11, ~^6'h11, 1'b0);
		wait_idle();
		chk("msg word", 37'h00_0000_0011, mem_m.mem[10'h210]);
		chk("msg cw", cw(0, 0, 9'h000, 3'h0, 17'h00211), mem_m.mem[10'h065]);
		chk("msg irq", 1, n_md);
		slow = 1'b0;
	endtask : t_rx_msg

	task automatic t_rx_ctrl();
		mem_m.mem[10'h067] = cw(0, 0, 9'h004, 3'h0, 17'h00230);
		mem_m.mem[10'h069] = cw(0, 0, 9'h003, 3'h2, 17'h00220);
		strobe(3, 6'h05, ^6'h05, 1'b1);
		strobe(5, 6'h3F, ~^6'h3F, 1'b0);
		wait_idle();
		chk("ctl cw", cw(1, 1, 9'h004, 3'h0, 17'h00230), mem_m.mem[10'h067]);
		chk("ctl loc", 11'h0C5, mem_m.mem[10'h0B1][10:0]);
		chk("ctl irq", 1, n_cc);
		chk("lamp", 1'b1, converter_parity_error_lamp);
		chk("2nd cw", cw(0, 0, 9'h003, 3'h3, 17'h00220), mem_m.mem[10'h069]);
		chk("2nd word", 37'h00_00FC_0000, mem_m.mem[10'h220]);
		lamp_clear = 1'b1;
		@(posedge core_clk);
		#1;
		lamp_clear = 1'b0;
		chk("lamp clr", 1'b0, converter_parity_error_lamp);
	endtask : t_rx_ctrl

	task automatic t_tx();
		mem_m.mem[10'h086] = cw(0, 0, 9'h001, 3'h1, 17'h00300);
		mem_m.mem[10'h300] = 37'h00_0000_0015;
		mem_m.send_order(6'h02, 5'h06);
		chk("bad op", '0, transmitter_active_bits);
		mem_m.send_order(OP_LOAD_TX, 5'h02);
		wait_idle();
		chk("tx cnt", 1, txq.size());
		chk("tx char", {1'b0, ~^6'h15, 5'h02, 6'h15}, txq.pop_front());
		chk("tx irq", 1, n_td);
		chk("irq chan", 5'h02, irq_chan);
		chk("tx cw", cw(0, 0, 9'h000, 3'h0, 17'h00301), mem_m.mem[10'h086]);
	endtask : t_tx

	task automatic t_tx_ctl();
		slow = 1'b1;
		mem_m.mem[10'h088] = cw(0, 1, 9'h002, 3'h3, 17'h00310);
		mem_m.mem[10'h310] = 37'h0C_C000_0000;
		mem_m.mem[10'h311] = 37'h03_0000_0000;
		mem_m.send_order(OP_LOAD_TX, 5'h04);
		wait_idle();
		wait_idle();
		chk("ctl tx cnt", 2, txq.size());
		chk("ctl tx 0", {1'b1, ~^6'h33, 5'h04, 6'h33}, txq.pop_front());
		chk("ctl tx 1", {1'b1, ~^6'h0C, 5'h04, 6'h0C}, txq.pop_front());
		chk("ctl words", 9'h000, mem_m.mem[10'h088][29:21]);
		chk("ctl addr", 17'h00312, mem_m.mem[10'h088][16:0]);
		chk("ctl irq", 2, n_td);
	endtask : t_tx_ctl

	initial
	begin
		rst = 1'b1;
		slow = 1'b0;
		lamp_clear = 1'b0;
		{rx_strobe, rx_parity, rx_ctrl} = '0;
		rx_data = '0;
		repeat (2) @(posedge core_clk);
		#1;
		rst = 1'b0;
		@(posedge core_clk);
		#1;
		chk("busy", 1'b0, busy);
		chk("strobe bits", '0, strobe_active_bits);
		t_rx_data();
		t_rx_msg();
		t_rx_ctrl();
		t_tx();
		t_tx_ctl();
		tally_and_finish();
	end
endmodule : tb_mcc_top
